//--- did_top.sv
`timescale 1ns/1ps
`include "did_consts.svh"
module did_top #(
  parameter int unsigned TICK_CYCLES = `DID_TICK_CYCLES
) (
  input logic sys_clk,
  input logic arst_n,
  input logic ce,
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [7:0] paddr,
  input did_pkg::did_word_t pwdata,
  output did_pkg::did_word_t prdata,
  output logic pready,
  output logic pslverr,
  input logic [15:0] din,
  input logic profile_running,
  input logic profile_held,
  output logic start_cmd,
  output logic pause_cmd,
  output logic resume_cmd,
  output logic term_cmd,
  output logic event_clear,
  output logic silence_cmd,
  output logic [15:0] alarm_lat,
  output logic alarm_any,
  output logic [15:0] out_force_off,
  output logic [15:0] out_ctrl_lvl,
  output logic [15:0] wait_lvl,
  output logic log_enable,
  output logic setpoint_tx_inhibit,
  output logic sp_follow_loop,
  output logic defrost_abort,
  output logic defrost_skip,
  output logic load_tmr_start
);
  import did_pkg::*;
  localparam int NCH = 16;

  function automatic logic [15:0] did_sel(input did_func_arr_t f, input did_func_t m);
    logic [15:0] r;
    r = 16'h0000;
    for (int i = 0; i < NCH; i++) begin
      r[i] = (f[i] == m);
    end
    return r;
  endfunction : did_sel

  function automatic logic [15:0] did_or_masks(input logic [15:0] s, input did_mask_arr_t m);
    logic [15:0] r;
    r = 16'h0000;
    for (int i = 0; i < NCH; i++) begin
      if (s[i]) begin
        r = r | m[i];
      end
    end
    return r;
  endfunction : did_or_masks

  function automatic logic did_hit(input logic [7:0] a, input logic [7:0] base);
    return a[7:6] == base[7:6];
  endfunction : did_hit

  did_func_arr_t cfg_func_reg;
  logic [15:0] cfg_rise_reg;
  logic [14:0] cfg_dly_reg [16];
  did_mask_arr_t out_mask_reg;
  did_mask_arr_t in_mask_reg;
  logic ext_reg;
  logic [23:0] tick_cnt_reg;
  logic tick_reg;
  logic [15:0] alarm_reg;
  logic [15:0] act_v;
  logic [15:0] fire_v;
  logic [15:0] en;
  logic [15:0] defeat;
  logic [15:0] eact;
  logic [15:0] efire;
  logic [15:0] alarm_src;
  logic [15:0] alarm_next;
  logic [15:0] force_next;
  logic alarm_rst;
  logic arst_cmd;
  logic inh_next;
  logic setup;
  logic wr_en;
  logic [3:0] idx;
  did_word_t rd_next;
  logic err_next;
  logic diag_hit;
  did_func_t wr_func;
  logic [14:0] wr_dly;

  assign setup = psel && !penable;
  assign wr_en = psel && penable && pready && pwrite && !pslverr;
  assign idx = paddr[5:2];
  assign arst_cmd = wr_en && (paddr == `DID_CTRL_OFS) && pwdata[`DID_CTRL_ARST_BIT];
  assign alarm_lat = alarm_reg;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      tick_cnt_reg <= 24'h000000;
      tick_reg <= 1'h0;
    end else if (ce) begin
      if (tick_cnt_reg == 24'(TICK_CYCLES - 1)) begin
        tick_cnt_reg <= 24'h000000;
        tick_reg <= 1'h1;
      end else begin
        tick_cnt_reg <= tick_cnt_reg + 24'h000001;
        tick_reg <= 1'h0;
      end
    end
  end

  for (genvar g = 0; g < NCH; g++) begin : g_ch
    did_chan_if ch_if ();
    assign ch_if.ce = ce;
    assign ch_if.tick = tick_reg;
    assign ch_if.raw = din[g];
    assign ch_if.rising = cfg_rise_reg[g];
    assign ch_if.delay = cfg_dly_reg[g];
    assign act_v[g] = ch_if.act;
    assign fire_v[g] = ch_if.fire;
    did_chan u_chan (
      .sys_clk(sys_clk),
      .arst_n(arst_n),
      .bus(ch_if.chan)
    );
  end

  always_comb begin
    wr_func = did_func_t'(pwdata[3:0]);
    if (pwdata[3:0] > FN_LOADTMR) begin
      wr_func = FN_NONE;
    end
    wr_dly = pwdata[30:16];
    if (wr_dly > `DID_DELAY_MAX) begin
      wr_dly = `DID_DELAY_MAX;
    end
  end

  always_comb begin
    rd_next = 32'h00000000;
    err_next = 1'h0;
    if (paddr[1:0] != 2'h0) begin
      err_next = 1'h1;
    end else if (paddr == `DID_CTRL_OFS) begin
      rd_next[`DID_CTRL_EXT_BIT] = ext_reg;
    end else if (paddr == `DID_STAT_OFS) begin
      rd_next = {defeat & en, eact};
    end else if (paddr == `DID_ALRM_OFS) begin
      rd_next = {16'h0000, alarm_reg};
    end else if (did_hit(paddr, `DID_CFG_BASE)) begin
      rd_next[3:0] = cfg_func_reg[idx];
      rd_next[`DID_CFG_RISE_BIT] = cfg_rise_reg[idx];
      rd_next[30:16] = cfg_dly_reg[idx];
    end else if (did_hit(paddr, `DID_MSK_BASE)) begin
      rd_next = {in_mask_reg[idx], out_mask_reg[idx]};
    end else begin
      err_next = 1'h1;
    end
  end

  // Read data is captured in the setup cycle so every access has no wait state.
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      pready <= 1'h0;
      prdata <= 32'h00000000;
      pslverr <= 1'h0;
    end else if (ce) begin
      pready <= setup;
      if (setup) begin
        prdata <= rd_next;
        pslverr <= err_next;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      ext_reg <= `DID_CTRL_EXT_RST;
      cfg_rise_reg <= {NCH{`DID_CFG_RISE_RST}};
      for (int i = 0; i < NCH; i++) begin
        cfg_func_reg[i] <= FN_NONE;
        cfg_dly_reg[i] <= `DID_DELAY_RST;
        out_mask_reg[i] <= `DID_MASK_RST;
        in_mask_reg[i] <= `DID_MASK_RST;
      end
    end else if (ce && wr_en) begin
      if (paddr == `DID_CTRL_OFS) begin
        ext_reg <= pwdata[`DID_CTRL_EXT_BIT];
      end else if (did_hit(paddr, `DID_CFG_BASE)) begin
        cfg_func_reg[idx] <= wr_func;
        cfg_rise_reg[idx] <= pwdata[`DID_CFG_RISE_BIT];
        cfg_dly_reg[idx] <= wr_dly;
      end else if (did_hit(paddr, `DID_MSK_BASE)) begin
        out_mask_reg[idx] <= pwdata[15:0];
        in_mask_reg[idx] <= pwdata[31:16] & ~(16'h0001 << idx);
      end
    end
  end

  // Suppression is computed from unsuppressed levels so there is no loop.
  always_comb begin
    en = ext_reg ? `DID_FULL_EN : `DID_BASE_EN;
    defeat = did_or_masks(act_v & en & did_sel(cfg_func_reg, FN_INDEF), in_mask_reg);
    eact = act_v & en & ~defeat;
    efire = fire_v & en & ~defeat;
    alarm_src = eact & did_sel(cfg_func_reg, FN_ALARM);
    alarm_rst = arst_cmd || |(efire & did_sel(cfg_func_reg, FN_SILENCE));
    alarm_next = alarm_src | (alarm_rst ? 16'h0000 : alarm_reg);
    force_next = did_or_masks(alarm_src | (eact & did_sel(cfg_func_reg, FN_OUTDEF)),
                              out_mask_reg);
    inh_next = |(eact & did_sel(cfg_func_reg, FN_SPINH));
    diag_hit = 1'h0;
    for (int i = 0; i < NCH; i++) begin
      diag_hit = diag_hit | in_mask_reg[i][i];
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      alarm_reg <= 16'h0000;
      alarm_any <= 1'h0;
      out_force_off <= 16'h0000;
    end else if (ce) begin
      alarm_reg <= alarm_next;
      alarm_any <= |alarm_next;
      out_force_off <= force_next;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      start_cmd <= 1'h0;
      pause_cmd <= 1'h0;
      resume_cmd <= 1'h0;
      term_cmd <= 1'h0;
      event_clear <= 1'h0;
      silence_cmd <= 1'h0;
      defrost_abort <= 1'h0;
      load_tmr_start <= 1'h0;
    end else if (ce) begin
      start_cmd <= |(efire & did_sel(cfg_func_reg, FN_START)) && !profile_running;
      pause_cmd <= |(efire & did_sel(cfg_func_reg, FN_PAUSE)) && profile_running
                   && !profile_held;
      resume_cmd <= |(efire & did_sel(cfg_func_reg, FN_RESUME)) && profile_running
                    && profile_held;
      term_cmd <= |(efire & did_sel(cfg_func_reg, FN_TERM)) && profile_running;
      event_clear <= |(efire & did_sel(cfg_func_reg, FN_TERM)) && profile_running;
      silence_cmd <= |(efire & did_sel(cfg_func_reg, FN_SILENCE));
      defrost_abort <= |(efire & did_sel(cfg_func_reg, FN_DEFROST));
      load_tmr_start <= |(efire & did_sel(cfg_func_reg, FN_LOADTMR));
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      out_ctrl_lvl <= 16'h0000;
      wait_lvl <= 16'h0000;
      log_enable <= 1'h0;
      setpoint_tx_inhibit <= 1'h0;
      sp_follow_loop <= 1'h0;
      defrost_skip <= 1'h0;
    end else if (ce) begin
      out_ctrl_lvl <= eact & did_sel(cfg_func_reg, FN_OUTCTL);
      wait_lvl <= eact & did_sel(cfg_func_reg, FN_WAIT);
      log_enable <= |(eact & did_sel(cfg_func_reg, FN_LOG));
      setpoint_tx_inhibit <= inh_next;
      sp_follow_loop <= inh_next && (!profile_running || profile_held);
      defrost_skip <= |(eact & did_sel(cfg_func_reg, FN_DEFROST));
    end
  end

  start_gate_a: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    $rose(start_cmd) |-> !$past(profile_running))
    else $error("Start issued while a profile was running.");
  pause_gate_a: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    $rose(pause_cmd) |-> $past(profile_running) && !$past(profile_held))
    else $error("Pause issued without a running profile.");
  resume_gate_a: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    $rose(resume_cmd) |-> $past(profile_running) && $past(profile_held))
    else $error("Resume issued without a held profile.");
  term_events_a: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    $rose(term_cmd) |-> event_clear && $past(profile_running))
    else $error("Terminate did not pair with an event clear.");
  alarm_hold_a: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    ((~alarm_reg & $past(alarm_reg)) != 16'h0000) |-> $past(alarm_rst)
    && ((~alarm_reg & $past(alarm_reg) & $past(alarm_src)) == 16'h0000))
    else $error("Alarm cleared without a reset or while still active.");
  self_mask_a: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    !diag_hit)
    else $error("An input suppresses itself.");
  sp_follow_a: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    sp_follow_loop |-> setpoint_tx_inhibit
    && (!$past(profile_running) || $past(profile_held)))
    else $error("Setpoint follows the loop under a running profile.");
  force_alarm_a: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    ce && (alarm_src != 16'h0000) |=> alarm_any)
    else $error("Active alarm input did not raise the alarm.");
  alarm_set_a: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    ce && (alarm_src != 16'h0000) |=> (alarm_reg & $past(alarm_src)) == $past(alarm_src))
    else $error("Active alarm input was not latched.");
  func_excl_a: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    (wait_lvl & out_ctrl_lvl) == 16'h0000)
    else $error("An input drives two level functions at once.");
  ext_gate_a: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    !ext_reg |-> (eact[15:8] == 8'h00))
    else $error("An upper input acted without the extension.");
  wait_src_a: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    (wait_lvl & ~$past(act_v)) == 16'h0000)
    else $error("Wait level shown for an inactive input.");
  outctl_src_a: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    (out_ctrl_lvl & ~$past(act_v)) == 16'h0000)
    else $error("Output control level shown for an inactive input.");
  force_src_a: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    (out_force_off != 16'h0000) |-> ($past(eact) != 16'h0000))
    else $error("Outputs forced off with no active input.");
  log_src_a: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    log_enable |-> ($past(act_v) != 16'h0000))
    else $error("Logging enabled with no active input.");
  inhibit_src_a: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    setpoint_tx_inhibit |-> ($past(act_v) != 16'h0000))
    else $error("Setpoint transmission inhibited with no active input.");
  silence_src_a: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    silence_cmd |-> ($past(fire_v) != 16'h0000))
    else $error("Silence issued without a qualified edge.");
  skip_src_a: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    defrost_skip |-> ($past(act_v) != 16'h0000))
    else $error("Defrost skip raised with no active input.");
  load_src_a: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    load_tmr_start |-> ($past(fire_v) != 16'h0000))
    else $error("Load timer started without a qualified edge.");
endmodule : did_top

//--- did_consts.svh
`ifndef DID_CONSTS_SVH
`define DID_CONSTS_SVH
// Overview of operation
// - Eight inputs by default; a control bit extends the set to sixteen.
// - Each input picks rising or falling edge and then runs its function.
// - The action waits until the new level persists for 0.0 to 3276.0 s.
// - One function per input; a new one replaces the old; none does nothing.
// - Several inputs may share a function and each acts independently.
// - Alarm mode latches an alarm, forces masked outputs off, clears on a reset given once the input is inactive.
// - Start mode begins the profile once per edge unless already running.
// - Pause mode holds a running profile once per edge.
// - Resume mode runs a held profile once per edge, else nothing.
// - Terminate ends a running profile and clears events; otherwise nothing.
// - Wait mode supplies an active level for profile wait steps.
// - Output-control mode drives following outputs with its active state.
// - Output-suppress mode forces masked outputs off without an alarm.
// - Logging mode runs data logging while the input is active.
// - Setpoint-inhibit mode blocks setpoint transmissions while active.
// - While inhibited, shown setpoint follows the loop unless profile runs unheld.
// - Silence mode resets alarms once per edge; holding it resets nothing later.
// - Input-suppress mode blocks masked inputs; an input never masks itself.
// - Defrost-abort ends defrost once per edge; while active, due cycles skip.
// - Load-timer mode starts the load timer, restarting it if running.
// - Level functions count active on voltage in rising mode, absence in falling.
`define DID_CTRL_OFS 8'h00
`define DID_STAT_OFS 8'h04
`define DID_ALRM_OFS 8'h08
`define DID_CFG_BASE 8'h40
`define DID_MSK_BASE 8'h80
`define DID_CTRL_EXT_BIT 0
`define DID_CTRL_ARST_BIT 1
`define DID_CFG_RISE_BIT 8
`define DID_CFG_DLY_LSB 16
`define DID_CTRL_EXT_RST 1'h0
`define DID_CFG_RISE_RST 1'h1
`define DID_DELAY_RST 15'h0000
`define DID_MASK_RST 16'h0000
`define DID_DELAY_MAX 15'h7FF8
`define DID_BASE_EN 16'h00FF
`define DID_FULL_EN 16'hFFFF
`define DID_CLK_NS 50
`define DID_TICK_NS 100000000
`define DID_TICK_CYCLES (`DID_TICK_NS / `DID_CLK_NS)
`endif

//--- did_pkg.sv
package did_pkg;
  typedef logic [31:0] did_word_t;
  typedef enum logic [3:0] {
    FN_NONE = 4'h0, FN_ALARM, FN_START, FN_PAUSE, FN_RESUME, FN_TERM, FN_WAIT,
    FN_OUTCTL, FN_OUTDEF, FN_LOG, FN_SPINH, FN_SILENCE, FN_INDEF, FN_DEFROST, FN_LOADTMR
  } did_func_t;
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_QUAL = 2'h1,
    ST_ACT = 2'h3
  } did_state_t;
  typedef did_func_t did_func_arr_t [16];
  typedef logic [15:0] did_mask_arr_t [16];
endpackage : did_pkg

//--- did_chan_if.sv
`timescale 1ns/1ps
interface did_chan_if;
  logic ce;
  logic tick;
  logic raw;
  logic rising;
  logic [14:0] delay;
  logic act;
  logic fire;
  modport ctl (output ce, tick, raw, rising, delay, input act, fire);
  modport chan (input ce, tick, raw, rising, delay, output act, fire);
endinterface : did_chan_if

//--- did_chan.sv
`timescale 1ns/1ps
module did_chan (
  input logic sys_clk,
  input logic arst_n,
  did_chan_if.chan bus
);
  import did_pkg::*;
  logic sync1_reg;
  logic sync2_reg;
  logic lvl_prev_reg;
  did_state_t state_reg;
  logic [14:0] cnt_reg;
  logic act_reg;
  logic fire_reg;
  logic level;
  logic qual_done;
  logic [1:0] warm_reg;

  assign level = bus.rising ? sync2_reg : ~sync2_reg;
  assign qual_done = (state_reg == ST_QUAL) && level && (cnt_reg == 15'h0000);
  assign bus.act = act_reg;
  assign bus.fire = fire_reg;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      sync1_reg <= 1'h0;
      sync2_reg <= 1'h0;
      lvl_prev_reg <= 1'h0;
      warm_reg <= 2'h0;
    end else if (bus.ce) begin
      sync1_reg <= bus.raw;
      sync2_reg <= sync1_reg;
      lvl_prev_reg <= level;
      // Edges are ignored until the synchroniser and history hold real pin samples.
      if (warm_reg != 2'h3) begin
        warm_reg <= warm_reg + 2'h1;
      end
    end
  end

  // A level already present at reset is not an edge, so it never fires.
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= ST_IDLE;
      cnt_reg <= 15'h0000;
    end else if (bus.ce) begin
      case (state_reg)
        ST_IDLE: begin
          if ((warm_reg == 2'h3) && level && !lvl_prev_reg) begin
            state_reg <= ST_QUAL;
            cnt_reg <= bus.delay;
          end
        end
        ST_QUAL: begin
          if (!level) begin
            state_reg <= ST_IDLE;
          end else if (cnt_reg == 15'h0000) begin
            state_reg <= ST_ACT;
          end else if (bus.tick) begin
            cnt_reg <= cnt_reg - 15'h0001;
          end
        end
        ST_ACT: begin
          if (!level) begin
            state_reg <= ST_IDLE;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      act_reg <= 1'h0;
      fire_reg <= 1'h0;
    end else if (bus.ce) begin
      fire_reg <= qual_done;
      act_reg <= qual_done || ((state_reg == ST_ACT) && level);
    end
  end

  fire_delay_a: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    $rose(fire_reg) |-> ($past(cnt_reg) == 15'h0000) && $past(level))
    else $error("Input fired before its delay ran out.");
  act_cause_a: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    $rose(act_reg) |-> fire_reg)
    else $error("Input became active without qualification.");
endmodule : did_chan

//--- did_field.sv
`timescale 1ns/1ps
module did_field (
  input wire logic sys_clk,
  input wire logic [15:0] closed,
  input wire logic [15:0] bounce,
  output logic [15:0] din
);
  logic [15:0] chat;
  initial chat = 16'h0000;
  always @(posedge sys_clk) begin
    chat <= ~chat;
  end
  // An open contact leaves the line pulled to 0 V, so nothing stale is shown.
  // Closed applies 24 V; a bouncing contact chatters every cycle.
  assign din = (closed & ~bounce) | (bounce & chat);
endmodule : did_field

//--- testbench.sv
`timescale 1ns/1ps
`include "did_consts.svh"
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin n_mismatch++; \
  $display("Error t=%0t got %h exp %h", $time, (a), (b)); end end
module testbench;
  import did_pkg::*;
  logic sys_clk, arst_n, ce, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  did_word_t pwdata, prdata, rd;
  logic er, profile_running, profile_held;
  logic [15:0] closed, bounce, din, alarm_lat, out_force_off, out_ctrl_lvl, wait_lvl;
  logic start_cmd, pause_cmd, resume_cmd, term_cmd, event_clear, silence_cmd, alarm_any;
  logic log_enable, setpoint_tx_inhibit, sp_follow_loop, defrost_abort, defrost_skip;
  logic load_tmr_start;
  logic [7:0] pv;
  logic [5:0] lv;
  int n_mismatch = 0;
  int n_tests = 0;
  int cnt [8] = '{default: 0};
  int exp_c [8] = '{default: 0};
  did_top #(.TICK_CYCLES(10)) u_did_top (.sys_clk(sys_clk), .arst_n(arst_n), .ce(ce),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .din(din),
    .profile_running(profile_running), .profile_held(profile_held),
    .start_cmd(start_cmd), .pause_cmd(pause_cmd), .resume_cmd(resume_cmd),
    .term_cmd(term_cmd), .event_clear(event_clear), .silence_cmd(silence_cmd),
    .alarm_lat(alarm_lat), .alarm_any(alarm_any), .out_force_off(out_force_off),
    .out_ctrl_lvl(out_ctrl_lvl), .wait_lvl(wait_lvl), .log_enable(log_enable),
    .setpoint_tx_inhibit(setpoint_tx_inhibit), .sp_follow_loop(sp_follow_loop),
    .defrost_abort(defrost_abort), .defrost_skip(defrost_skip),
    .load_tmr_start(load_tmr_start));
  did_field u_did_field (.sys_clk(sys_clk), .closed(closed), .bounce(bounce), .din(din));
  assign pv = {load_tmr_start, defrost_abort, silence_cmd, event_clear, term_cmd,
    resume_cmd, pause_cmd, start_cmd};
  assign lv = {out_ctrl_lvl[0], log_enable, setpoint_tx_inhibit, sp_follow_loop,
    defrost_skip, wait_lvl[0]};
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  // Pulse counters feed the bench model; a pulse stands for one cycle only.
  always @(posedge sys_clk) begin
    for (int k = 0; k < 8; k++) if (pv[k] === 1'b1) cnt[k]++;
  end
  task stop_test();
    $display("tests %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : stop_test
  task apb(input logic w, input logic [7:0] a, input did_word_t d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask : apb
  task cfg(input int i, input did_func_t f, input logic r, input logic [14:0] dl);
    apb(1'b1, `DID_CFG_BASE + 8'(4 * i), {1'b0, dl, 7'h00, r, 4'h0, f});
  endtask : cfg
  task waitc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : waitc
  task chk_cnt();
    for (int k = 0; k < 8; k++) `CHK(cnt[k], exp_c[k])
  endtask : chk_cnt
  task pcase(input did_func_t f, input logic run, input logic hold, input int k, input int a);
    cfg(0, f, 1'b1, 15'h0000);
    profile_running <= run;
    profile_held <= hold;
    closed[0] <= 1'b1;
    waitc(40);
    closed[0] <= 1'b0;
    waitc(40);
    exp_c[k] += a;
    if (f == FN_TERM) exp_c[4] += a;
    chk_cnt();
  endtask : pcase
  task lcase(input did_func_t f, input logic [5:0] e, input logic [15:0] fo);
    cfg(0, f, 1'b1, 15'h0000);
    closed[0] <= 1'b1;
    waitc(40);
    `CHK(lv, e)
    `CHK(out_force_off, fo)
    closed[0] <= 1'b0;
    waitc(40);
    `CHK(lv, 6'h00)
  endtask : lcase
  initial begin
    repeat (20000) @(posedge sys_clk);
    n_mismatch++;
    stop_test();
  end
  initial begin
    arst_n = 1'b0;
    ce = 1'b1;
    {psel, penable, pwrite, profile_running, profile_held} = '0;
    paddr = 8'h00;
    pwdata = 32'h0;
    closed = 16'h0000;
    bounce = 16'h0000;
    void'($urandom(32'hCA8AAFAC));
    waitc(8);
    arst_n <= 1'b1;
    waitc(1);
    `CHK({alarm_lat, out_force_off}, 32'h0)
    apb(1'b0, `DID_CFG_BASE, 32'h0);
    `CHK(rd, 32'h00000100)
    apb(1'b0, `DID_CTRL_OFS, 32'h0);
    `CHK(rd, 32'h0)
    apb(1'b0, 8'h0C, 32'h0);
    `CHK(er, 1'b1)
    apb(1'b1, 8'h41, 32'h0);
    `CHK(er, 1'b1)
    cfg(5, did_func_t'(4'hF), 1'b0, 15'h7FFF);
    apb(1'b0, `DID_CFG_BASE + 8'h14, 32'h0);
    `CHK(rd, 32'h7FF80000)
    apb(1'b1, `DID_MSK_BASE + 8'h04, 32'hFFFF0030);
    apb(1'b0, `DID_MSK_BASE + 8'h04, 32'h0);
    `CHK(rd, 32'hFFFD0030)
    // Alarm latches, survives a reset while active, then silence clears it.
    cfg(2, FN_ALARM, 1'b1, 15'h0000);
    apb(1'b1, `DID_MSK_BASE + 8'h08, 32'h00000005);
    closed[2] <= 1'b1;
    waitc(40);
    `CHK({alarm_any, alarm_lat, out_force_off}, 33'h100040005)
    apb(1'b1, `DID_CTRL_OFS, 32'h2);
    closed[2] <= 1'b0;
    waitc(40);
    `CHK({alarm_any, alarm_lat, out_force_off}, 33'h100040000)
    pcase(FN_SILENCE, 1'b0, 1'b0, 5, 1);
    `CHK(alarm_lat, 16'h0000)
    pcase(FN_START, 1'b0, 1'b0, 0, 1);
    pcase(FN_START, 1'b1, 1'b0, 0, 0);
    pcase(FN_PAUSE, 1'b1, 1'b0, 1, 1);
    pcase(FN_PAUSE, 1'b0, 1'b0, 1, 0);
    pcase(FN_RESUME, 1'b1, 1'b1, 2, 1);
    pcase(FN_RESUME, 1'b1, 1'b0, 2, 0);
    pcase(FN_TERM, 1'b1, 1'b0, 3, 1);
    pcase(FN_TERM, 1'b0, 1'b0, 3, 0);
    pcase(FN_DEFROST, 1'b0, 1'b0, 6, 1);
    pcase(FN_LOADTMR, 1'b0, 1'b0, 7, 1);
    pcase(FN_LOADTMR, 1'b0, 1'b0, 7, 1);
    pcase(FN_NONE, 1'b0, 1'b0, 0, 0);
    apb(1'b1, `DID_MSK_BASE, 32'h00000030);
    lcase(FN_WAIT, 6'h01, 16'h0000);
    lcase(FN_OUTCTL, 6'h20, 16'h0000);
    lcase(FN_OUTDEF, 6'h00, 16'h0030);
    lcase(FN_LOG, 6'h10, 16'h0000);
    lcase(FN_SPINH, 6'h0C, 16'h0000);
    lcase(FN_DEFROST, 6'h02, 16'h0000);
    exp_c[6]++;
    cfg(1, FN_WAIT, 1'b0, 15'h0000);
    closed[1] <= 1'b1;
    waitc(40);
    closed[1] <= 1'b0;
    waitc(40);
    `CHK(wait_lvl[1], 1'b1)
    cfg(0, FN_SPINH, 1'b1, 15'h0000);
    profile_running <= 1'b1;
    closed[0] <= 1'b1;
    waitc(40);
    `CHK(sp_follow_loop, 1'b0)
    profile_held <= 1'b1;
    waitc(10);
    `CHK(sp_follow_loop, 1'b1)
    closed[0] <= 1'b0;
    profile_running <= 1'b0;
    profile_held <= 1'b0;
    // Chatter keeps restarting the qualification; only a steady level fires.
    cfg(3, FN_START, 1'b1, 15'h0003);
    bounce[3] <= 1'b1;
    closed[3] <= 1'b1;
    waitc(60);
    bounce[3] <= 1'b0;
    waitc(25);
    chk_cnt();
    waitc(50);
    exp_c[0]++;
    chk_cnt();
    closed[3] <= 1'b0;
    cfg(4, FN_INDEF, 1'b1, 15'h0000);
    apb(1'b1, `DID_MSK_BASE + 8'h10, 32'h00080000);
    closed[4] <= 1'b1;
    waitc(40);
    closed[3] <= 1'b1;
    waitc(80);
    closed[3] <= 1'b0;
    waitc(40);
    chk_cnt();
    closed[4] <= 1'b0;
    cfg(8, FN_START, 1'b1, 15'h0000);
    cfg(9, FN_START, 1'b1, 15'h0000);
    for (int p = 0; p < 2; p++) begin
      if (p == 1) apb(1'b1, `DID_CTRL_OFS, 32'h1);
      closed[8] <= 1'b1;
      waitc(20);
      closed[9] <= 1'b1;
      waitc(40);
      closed[9:8] <= 2'b00;
      waitc(40);
      exp_c[0] += 2 * p;
      chk_cnt();
    end
    // With the clock enable low nothing may qualify; the edge is taken once it returns.
    ce <= 1'b0;
    closed[3] <= 1'b1;
    waitc(100);
    chk_cnt();
    ce <= 1'b1;
    waitc(60);
    exp_c[0]++;
    chk_cnt();
    closed[3] <= 1'b0;
    repeat (200) begin
      closed[15:10] <= 6'($urandom);
      profile_running <= 1'($urandom);
      @(posedge sys_clk);
    end
    closed[15:10] <= 6'h00;
    waitc(40);
    chk_cnt();
    `CHK(alarm_any, 1'b0)
    stop_test();
  end
endmodule : testbench
